// [shared/prtr_pkg.sv]
// Summary of operation
// - bcd slave treats values above 999 as bits
// - request carries local, remote start and count
// - count limited to 16 or 64
// - read stores remote run into local run
// - write sends local run into remote run
// - status bit 22 shows enable continuity
// - status bit 17 set when message sent
// - status bit 16 set when transfer done
// - status bit 15 shows remote halt/run
// - status bits 1 to 14 carry error code
// - remote returns status, initiator stores it
// - status persists while enabled, clears when disabled
// - enable sets bit 22, disable resets request
// - status value 1 to 16000 is error code
package prtr_pkg;
   localparam int unsigned PRTR_NREG = 64;            // local register file depth
   localparam int unsigned PRTR_AW = 16;               // register address width
   localparam int unsigned PRTR_CW = 7;                // count width (0..64)
   localparam logic [6:0] PRTR_MAX_SMALL = 7'h10;      // smaller variant limit
   localparam logic [6:0] PRTR_MAX_LARGE = 7'h40;      // larger variant limit
   localparam logic [15:0] PRTR_BCD_LIMIT = 16'h03e7;  // numeric ceiling of bcd slave
   localparam logic [13:0] PRTR_ERR_COUNT = 14'h0003;  // illegal count code
   // status word bit positions (1-based numbering kept in a 22 bit word)
   localparam int unsigned ST_EN = 21;                 // bit 22
   localparam int unsigned ST_SENT = 16;               // bit 17
   localparam int unsigned ST_DONE = 15;               // bit 16
   localparam int unsigned ST_RUN = 14;                // bit 15
   localparam int unsigned ST_ERR_LO = 0;              // bits 1..14
   // register map (byte addresses)
   localparam logic [7:0] A_CTRL = 8'h00;     // en, dir, large variant
   localparam logic [7:0] A_LOCAL = 8'h04;    // local start
   localparam logic [7:0] A_REMOTE = 8'h08;   // remote start
   localparam logic [7:0] A_COUNT = 8'h0c;    // count
   localparam logic [7:0] A_STATUS = 8'h10;   // transfer_status_word
   localparam logic [7:0] A_DATA = 8'h40;     // local register window base
   localparam int unsigned C_EN = 0;          // ctrl bit: initiating condition
   localparam int unsigned C_WR = 1;          // ctrl bit: 1 write, 0 read
   localparam int unsigned C_LARGE = 2;       // ctrl bit: larger variant
   localparam logic [1:0] RESP_OK = 2'b00;    // okay
   localparam logic [1:0] RESP_ERR = 2'b10;   // slverr on unmapped
   typedef struct packed {
      logic wr;                // 1 write, 0 read
      logic [15:0] remote;     // remote register address
      logic [15:0] wdata;      // data toward remote
   } prtr_word_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SEND = 4'b0010,
      S_WAIT = 4'b0100,
      S_DONE = 4'b1000
   } prtr_state_t;
endpackage

// [hdl/prtr_core.sv]
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
module prtr_core import prtr_pkg::*; (
   input wire logic aclk,                 // 200 MHz clock
   input wire logic aresetn,              // sync reset, low active
   input wire logic [7:0] s_awaddr,       // axi write address
   input wire logic s_awvalid,            // aw valid
   output logic s_awready,                // aw ready
   input wire logic [31:0] s_wdata,       // write data
   input wire logic [3:0] s_wstrb,        // byte strobes
   input wire logic s_wvalid,             // w valid
   output logic s_wready,                 // w ready
   output logic [1:0] s_bresp,            // write response
   output logic s_bvalid,                 // b valid
   input wire logic s_bready,             // b ready
   input wire logic [7:0] s_araddr,       // read address
   input wire logic s_arvalid,            // ar valid
   output logic s_arready,                // ar ready
   output logic [31:0] s_rdata,           // read data
   output logic [1:0] s_rresp,            // read response
   output logic s_rvalid,                 // r valid
   input wire logic s_rready,             // r ready
   output prtr_word_t net_req,            // word toward remote
   output logic net_req_valid,            // word offered
   input wire logic net_req_ready,        // remote takes word
   input wire logic net_rsp_valid,        // answer word from remote
   input wire logic [15:0] net_rsp_data,  // read data from remote
   input wire logic net_rsp_last,         // final answer, carries status
   input wire logic net_rsp_halted,       // remote halted flag
   input wire logic [13:0] net_rsp_err,   // remote error code
   output logic bcd_range_warn            // a written value exceeds 999
);
   // software-visible control
   logic en_ff;                    // initiating condition
   logic wr_ff;                    // direction
   logic large_ff;                 // larger variant selected
   logic [15:0] local_ff;          // local start
   logic [15:0] remote_ff;         // remote start
   logic [6:0] count_ff;           // register count
   logic [21:0] status_ff;         // transfer_status_word
   logic [15:0] mem [PRTR_NREG];   // local registers
   logic [6:0] idx_ff;             // word index within run
   logic fired_ff;                 // message launched on this enable
   logic warn_ff;                  // range warning
   prtr_state_t st_ff, nxt_st;     // transfer sequencer
   // axi slave state
   logic aw_got_ff, w_got_ff;      // halves of a write held
   logic [7:0] awaddr_ff;          // latched write address
   logic [31:0] wdata_ff;          // latched write data
   logic ar_busy;                  // read answer outstanding

   // local register index, wraps inside the array
   function automatic logic [5:0] loc_idx(input logic [15:0] base, input logic [6:0] off);
      logic [15:0] s;
      s = base + {9'h000, off};
      return s[5:0];
   endfunction

   // local register index of a bus address inside the window
   function automatic logic [5:0] win_idx(input logic [7:0] a);
      return a[7:2] - A_DATA[7:2];
   endfunction

   // count check against the selected variant
   logic [6:0] max_cnt;
   logic cnt_ok;
   assign max_cnt = large_ff ? PRTR_MAX_LARGE : PRTR_MAX_SMALL;
   assign cnt_ok = (count_ff != 7'h00) && (count_ff <= max_cnt);

   // write channel: address and data taken in any order
   // readiness drops while a response waits, so one write at most is in flight
   assign s_awready = !aw_got_ff && !s_bvalid;
   assign s_wready = !w_got_ff && !s_bvalid;
   logic do_wr;
   logic [7:0] wa;
   logic [31:0] wd;
   assign wa = s_awvalid && s_awready ? s_awaddr : awaddr_ff;
   assign wd = s_wvalid && s_wready ? s_wdata : wdata_ff;
   assign do_wr = (aw_got_ff || (s_awvalid && s_awready)) && (w_got_ff || (s_wvalid && s_wready));
   logic wr_hit;
   assign wr_hit = (wa == A_CTRL) || (wa == A_LOCAL) || (wa == A_REMOTE) || (wa == A_COUNT) ||
                   (wa >= A_DATA);

   // write handshake bookkeeping
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OK;
      end else begin
         if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
         if (do_wr) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= wr_hit ? RESP_OK : RESP_ERR;
         end else begin
            if (s_awvalid && s_awready) begin
               aw_got_ff <= 1'b1;
               awaddr_ff <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
               w_got_ff <= 1'b1;
               wdata_ff <= s_wdata;
            end
         end
      end
   end

   // request parameters; held fixed while a message is under way
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_ff <= 1'b0;
         wr_ff <= 1'b0;
         large_ff <= 1'b0;
         local_ff <= 16'h0000;
         remote_ff <= 16'h0000;
         count_ff <= 7'h00;
      end else if (do_wr && s_wstrb[0]) begin
         case (wa)
            A_CTRL: begin
               en_ff <= wd[C_EN];
               if (st_ff == S_IDLE) begin
                  wr_ff <= wd[C_WR];
                  large_ff <= wd[C_LARGE];
               end
            end
            A_LOCAL: if (st_ff == S_IDLE) local_ff <= wd[15:0];
            A_REMOTE: if (st_ff == S_IDLE) remote_ff <= wd[15:0];
            A_COUNT: if (st_ff == S_IDLE) count_ff <= wd[6:0];
            default: ;
         endcase
      end
   end

   // sequencer next state
   // dropping the enable returns any state to idle; words already moved stay where they landed
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         S_IDLE: if (en_ff && !fired_ff && cnt_ok) nxt_st = S_SEND;
         S_SEND: if (!en_ff) nxt_st = S_IDLE;
                 else if (net_req_valid && net_req_ready && (!wr_ff || idx_ff == count_ff - 7'h01)) nxt_st = S_WAIT;
         S_WAIT: if (!en_ff) nxt_st = S_IDLE;
                 else if (net_rsp_valid && net_rsp_last) nxt_st = S_DONE;
         S_DONE: if (!en_ff) nxt_st = S_IDLE;
         default: nxt_st = S_IDLE;
      endcase
   end

   // state and index
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= S_IDLE;
         idx_ff <= 7'h00;
         fired_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         if (!en_ff) begin
            fired_ff <= 1'b0;
         end else if (st_ff == S_IDLE && nxt_st == S_SEND) begin
            fired_ff <= 1'b1;
         end
         if (st_ff == S_IDLE) begin
            idx_ff <= 7'h00;
         end else if (st_ff == S_SEND && nxt_st == S_WAIT) begin
            idx_ff <= 7'h00;                 // read answers restart at zero
         end else if ((st_ff == S_SEND && net_req_valid && net_req_ready) ||
                      (st_ff == S_WAIT && net_rsp_valid && !wr_ff)) begin
            idx_ff <= idx_ff + 7'h01;
         end
      end
   end

   // outgoing word: write carries local data, read carries header only
   assign net_req_valid = (st_ff == S_SEND);
   always_comb begin
      net_req.wr = wr_ff;
      net_req.remote = remote_ff + {9'h000, idx_ff};
      net_req.wdata = wr_ff ? mem[loc_idx(local_ff, idx_ff)] : 16'h0000;
   end

   // flag values a bcd slave would treat as bit patterns
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warn_ff <= 1'b0;
      end else if (!en_ff) begin
         warn_ff <= 1'b0;
      end else if (net_req_valid && net_req_ready && wr_ff && net_req.wdata > PRTR_BCD_LIMIT) begin
         warn_ff <= 1'b1;
      end
   end
   assign bcd_range_warn = warn_ff;

   // local memory: software writes and read answers
   // a read answer wins over a software write in the same cycle; that bus write is lost
   always_ff @(posedge aclk) begin
      if (st_ff == S_WAIT && net_rsp_valid && !wr_ff && en_ff) begin
         mem[loc_idx(local_ff, idx_ff)] <= net_rsp_data;
      end else if (do_wr && wa >= A_DATA && s_wstrb[0]) begin
         mem[win_idx(wa)] <= wd[15:0];
      end
   end

   // status word
   // a bad count never reaches the link; it is reported like a remote error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= 22'h000000;
      end else if (!en_ff) begin
         status_ff <= 22'h000000;
      end else begin
         status_ff[ST_EN] <= 1'b1;
         if (st_ff == S_IDLE && !fired_ff && !cnt_ok) begin
            status_ff[ST_ERR_LO +: 14] <= PRTR_ERR_COUNT;
            status_ff[ST_DONE] <= 1'b1;
         end
         if (st_ff == S_SEND && nxt_st == S_WAIT) begin
            status_ff[ST_SENT] <= 1'b1;
         end
         if (st_ff == S_WAIT && net_rsp_valid && net_rsp_last) begin
            status_ff[ST_DONE] <= 1'b1;
            status_ff[ST_RUN] <= net_rsp_halted;
            status_ff[ST_ERR_LO +: 14] <= net_rsp_err;
         end
      end
   end

   // read channel
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_araddr)
         A_CTRL: rd_mux = {29'h0000_0000, large_ff, wr_ff, en_ff};
         A_LOCAL: rd_mux = {16'h0000, local_ff};
         A_REMOTE: rd_mux = {16'h0000, remote_ff};
         A_COUNT: rd_mux = {25'h000_0000, count_ff};
         A_STATUS: rd_mux = {10'h000, status_ff};
         default: begin
            if (s_araddr >= A_DATA) rd_mux = {16'h0000, mem[win_idx(s_araddr)]};
            else rd_hit = 1'b0;
         end
      endcase
   end
   assign ar_busy = s_rvalid;
   assign s_arready = !ar_busy;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OK;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_mux;
         s_rresp <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   // checks
   // status word follows the enable
   chk_clear_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !en_ff |=> status_ff == 22'h000000) else $error("status not cleared");
   chk_enable_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(en_ff) |=> status_ff[ST_EN]) else $error("bit 22 not set");
   chk_sent_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_SEND && nxt_st == S_WAIT) |=> status_ff[ST_SENT]) else $error("sent bit missing");
   // final answer from the remote lands in the status word
   chk_done_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_WAIT && en_ff && net_rsp_valid && net_rsp_last) |=> status_ff[ST_DONE] && st_ff == S_DONE)
      else $error("done bit missing");
   chk_halt_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_WAIT && en_ff && net_rsp_valid && net_rsp_last) |=> status_ff[ST_RUN] == $past(net_rsp_halted))
      else $error("halt flag wrong");
   chk_err_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_WAIT && en_ff && net_rsp_valid && net_rsp_last) |=> status_ff[13:0] == $past(net_rsp_err))
      else $error("error code wrong");
   // a bad count is reported without touching the link
   chk_bad_count: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_IDLE && en_ff && !fired_ff && !cnt_ok) |=> status_ff[ST_ERR_LO +: 14] == PRTR_ERR_COUNT)
      else $error("count error code missing");
   chk_one_shot: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_DONE && en_ff) |=> st_ff != S_SEND) else $error("second message");
   chk_count_lim: assert property (@(posedge aclk) disable iff (!aresetn)
      net_req_valid |-> count_ff <= max_cnt && count_ff != 7'h00) else $error("count over limit");
   chk_rst_req: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(en_ff) |-> ##1 st_ff == S_IDLE) else $error("request not reset");
   // data path and range flag
   chk_read_store: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff == S_WAIT && en_ff && net_rsp_valid && !wr_ff) |=>
      mem[$past(loc_idx(local_ff, idx_ff))] == $past(net_rsp_data)) else $error("read word not stored");
   chk_warn_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (en_ff && net_req_valid && net_req_ready && wr_ff && net_req.wdata > PRTR_BCD_LIMIT) |=> bcd_range_warn)
      else $error("range warning missing");
   cov_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_ff && st_ff == S_DONE);
   cov_read: cover property (@(posedge aclk) disable iff (!aresetn) !wr_ff && st_ff == S_DONE);
   cov_abort: cover property (@(posedge aclk) disable iff (!aresetn) (st_ff == S_SEND || st_ff == S_WAIT) && !en_ff);
   cov_bad_count: cover property (@(posedge aclk) disable iff (!aresetn) st_ff == S_IDLE && status_ff[ST_DONE]);
   cov_stall: cover property (@(posedge aclk) disable iff (!aresetn) net_req_valid && !net_req_ready);
endmodule

// [test/prtr_remote_model.sv]
`timescale 1ns/10ps
module prtr_remote_model import prtr_pkg::*; (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, low active
   input wire prtr_word_t net_req, // word from initiator
   input wire logic net_req_valid, // word offered
   output logic net_req_ready, // word taken
   output logic net_rsp_valid, // answer pulse
   output logic [15:0] net_rsp_data, // read data
   output logic net_rsp_last, // final answer
   output logic net_rsp_halted, // halt flag
   output logic [13:0] net_rsp_err, // error code
   input wire logic [6:0] cnt, // words per transfer
   input wire logic slow, // stall every other cycle
   input wire logic hlt, // report halted
   input wire logic [13:0] err, // error to report
   output int nwords // words taken so far
);
   logic [15:0] rmem [0:255]; // remote registers
   logic [6:0] got; // write words this transfer
   logic [6:0] rd_left; // read words still owed
   logic [7:0] ra; // read pointer
   logic pend; // write answer owed
   // take request words; the address is used as sent, never translated
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         net_req_ready <= 1'h0;
         got <= 7'h0;
         rd_left <= 7'h0;
         ra <= 8'h0;
         pend <= 1'h0;
         nwords <= 0;
         for (int i = 0; i < 256; i++) rmem[i] <= 16'(16'h0100 + i);
      end else begin
         net_req_ready <= slow ? ~net_req_ready : 1'h1; // slow mode stalls
         pend <= 1'h0;
         if (rd_left != 7'h0) begin
            rd_left <= rd_left - 7'h1;
            ra <= ra + 8'h1;
         end
         if (net_req_valid && net_req_ready) begin
            nwords <= nwords + 1;
            if (net_req.wr) begin
               rmem[net_req.remote[7:0]] <= net_req.wdata;
               got <= (got + 7'h1 == cnt) ? 7'h0 : got + 7'h1;
               pend <= (got + 7'h1 == cnt);
            end else begin
               rd_left <= cnt;
               ra <= net_req.remote[7:0];
            end
         end
      end
   end
   // answer words; status rides on the final one, data is junk between answers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         net_rsp_valid <= 1'h0;
         net_rsp_last <= 1'h0;
         net_rsp_data <= 16'h0;
         net_rsp_halted <= 1'h0;
         net_rsp_err <= 14'h0;
      end else begin
         net_rsp_valid <= pend || rd_left != 7'h0;
         net_rsp_last <= pend || rd_left == 7'h1;
         net_rsp_data <= (rd_left != 7'h0) ? rmem[ra] : ~net_rsp_data;
         net_rsp_halted <= hlt;
         net_rsp_err <= (pend || rd_left == 7'h1) ? err : 14'h0;
      end
   end
endmodule

// [test/peer_register_transfer_request_tb.sv]
`timescale 1ns/10ps
module peer_register_transfer_request_tb import prtr_pkg::*;;
   typedef struct packed {
      logic wr, lg, slow, hlt;
      logic [7:0] loc, rem;
      logic [6:0] cnt;
      logic [13:0] err;
      logic [15:0] base;
      logic wrn;
      logic [31:0] exp;
   } prtr_row_t;
   logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, net_req_valid, net_req_ready;
   logic net_rsp_valid, net_rsp_last, net_rsp_halted, bcd_range_warn, slow, hlt;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rd;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, resp;
   logic [15:0] net_rsp_data;
   logic [13:0] net_rsp_err, err_m;
   logic [6:0] cnt_m;
   prtr_word_t net_req;
   int err_count = 0, samples_checked = 0, nw;
   // transfers: dir, variant, stall, halt, local, remote, count, err, data base, warn, status
   prtr_row_t rows[8] = '{
      '{1'h1, 1'h0, 1'h0, 1'h0, 8'h02, 8'h14, 7'h03, 14'h0, 16'h00c8, 1'h0, 32'h218000},
      '{1'h0, 1'h0, 1'h1, 1'h1, 8'h08, 8'h1e, 7'h03, 14'h0, 16'h0000, 1'h0, 32'h21c000},
      '{1'h1, 1'h0, 1'h1, 1'h0, 8'h1e, 8'h3c, 7'h10, 14'h5, 16'h00c8, 1'h0, 32'h218005},
      '{1'h1, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 7'h11, 14'h0, 16'h00c8, 1'h0, 32'h208003},
      '{1'h0, 1'h1, 1'h0, 1'h0, 8'h0a, 8'h5a, 7'h11, 14'h0, 16'h0000, 1'h0, 32'h218000},
      '{1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 7'h00, 14'h0, 16'h0000, 1'h0, 32'h208003},
      '{1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 7'h41, 14'h0, 16'h00c8, 1'h0, 32'h208003},
      '{1'h1, 1'h0, 1'h0, 1'h0, 8'h00, 8'h05, 7'h01, 14'h0, 16'h03e8, 1'h1, 32'h218000}};
   prtr_core i_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .net_req, .net_req_valid, .net_req_ready,
      .net_rsp_valid, .net_rsp_data, .net_rsp_last, .net_rsp_halted, .net_rsp_err, .bcd_range_warn);
   prtr_remote_model i_model (.aclk, .aresetn, .net_req, .net_req_valid, .net_req_ready,
      .net_rsp_valid, .net_rsp_data, .net_rsp_last, .net_rsp_halted, .net_rsp_err,
      .cnt(cnt_m), .slow, .hlt, .err(err_m), .nwords(nw));
   // clock, 5 ns period
   initial begin
      aclk = 1'h0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // requester side binary to bcd, four digits
   function automatic logic [15:0] to_bcd(input int v);
      return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge aclk);
      s_awaddr <= a;
      s_awvalid <= 1'h1;
      s_wdata <= d;
      s_wstrb <= 4'hf;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_awready) begin
            aw_ok = 1'h1;
            s_awvalid <= 1'h0;
         end
         if (!w_ok && s_wready) begin
            w_ok = 1'h1;
            s_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (!s_bvalid);
      resp = s_bresp;
      s_bready <= 1'h0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do @(posedge aclk); while (!s_arready);
      s_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_rvalid);
      rd = s_rdata;
      resp = s_rresp;
      s_rready <= 1'h0;
   endtask
   // one full request: load, arm, wait for done, check, disarm
   task automatic run(input prtr_row_t r);
      int n0, ok;
      ok = r.cnt != 7'h0 && r.cnt <= (r.lg ? 7'h40 : 7'h10);
      cnt_m <= r.cnt;
      slow <= r.slow;
      hlt <= r.hlt;
      err_m <= r.err;
      for (int k = 0; k < r.cnt && r.wr && ok; k++) begin
         axi_wr(8'(A_DATA + 4 * (r.loc + k)), 32'(to_bcd(r.base + k * 7 + r.loc)));
      end
      axi_wr(A_LOCAL, 32'(r.loc));
      axi_wr(A_REMOTE, 32'(r.rem));
      axi_wr(A_COUNT, 32'(r.cnt));
      n0 = nw;
      axi_wr(A_CTRL, {29'h0, r.lg, r.wr, 1'h1});
      chk("arm_resp", resp, RESP_OK);
      do axi_rd(A_STATUS); while (!rd[ST_DONE]);
      repeat (20) @(posedge aclk);
      axi_rd(A_CTRL);
      chk("ctrl", rd, {29'h0, r.lg, r.wr, 1'h1});
      axi_rd(A_STATUS);
      chk("status", rd, r.exp);
      chk("messages", nw - n0, ok ? (r.wr ? r.cnt : 1) : 0);
      chk("range_warn", bcd_range_warn, r.wrn);
      for (int k = 0; k < r.cnt && ok; k++) begin
         if (r.wr) chk("remote", i_model.rmem[r.rem + k], 32'(to_bcd(r.base + k * 7 + r.loc)));
         else begin
            axi_rd(8'(A_DATA + 4 * (r.loc + k)));
            chk("local", rd, 16'(16'h0100 + r.rem + k));
         end
      end
      axi_wr(A_CTRL, 32'h0);
      axi_rd(A_STATUS);
      chk("cleared", rd, 32'h0);
      chk("warn_clear", bcd_range_warn, 1'h0);
   endtask
   // watchdog sized well above the expected run
   initial begin
      repeat (40000) @(posedge aclk);
      err_count++;
      tally_and_finish();
   end
   initial begin
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, slow, hlt} = 8'h0;
      {s_awaddr, s_araddr, s_wdata, s_wstrb, cnt_m, err_m} = 73'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(A_STATUS);
      chk("status_rst", rd, 32'h0);
      axi_rd(A_CTRL);
      chk("ctrl_rst", rd, 32'h0);
      foreach (rows[i]) run(rows[i]);
      // unmapped place and read-only status
      axi_rd(8'h20);
      chk("unmapped_resp", resp, RESP_ERR);
      chk("unmapped_data", rd, 32'h0);
      axi_wr(A_STATUS, 32'hffffffff);
      chk("status_wr_resp", resp, RESP_ERR);
      axi_rd(A_STATUS);
      chk("status_ro", rd, 32'h0);
      // abort a stalled write by dropping the enable
      cnt_m <= 7'h10;
      slow <= 1'h1;
      axi_wr(A_COUNT, 32'h10);
      axi_wr(A_CTRL, 32'h3);
      axi_rd(A_STATUS);
      chk("enabled", rd[ST_EN], 1'h1);
      chk("not_done", rd[ST_DONE], 1'h0);
      axi_wr(A_CTRL, 32'h0);
      axi_rd(A_STATUS);
      chk("abort_clear", rd, 32'h0);
      chk("abort_idle", net_req_valid, 1'h0);
      // second reset in the middle of a stalled write
      axi_wr(A_CTRL, 32'h3);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(A_STATUS);
      chk("status_rst2", rd, 32'h0);
      chk("idle_rst2", net_req_valid, 1'h0);
      axi_rd(A_CTRL);
      chk("ctrl_rst2", rd, 32'h0);
      chk("warn_rst2", bcd_range_warn, 1'h0);
      tally_and_finish();
   end
endmodule
